// [core/timer_pin_io_map.vh]
// Purpose: Register map and field layout of the timer pin function block
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes:   Included by the pin function block only
`ifndef TIMER_PIN_IO_MAP_VH
`define TIMER_PIN_IO_MAP_VH

// Bus geometry
`define TPIO_ADDR_W          5
`define TPIO_DATA_W          32
`define TPIO_BE_W            4

// Register byte offsets
`define TPIO_OFS_CH0_CTRL    5'h00
`define TPIO_OFS_CH1_CTRL    5'h04
`define TPIO_OFS_CH0_GEN_A   5'h08
`define TPIO_OFS_CH0_GEN_C   5'h0C
`define TPIO_OFS_CH1_GEN_A   5'h10
`define TPIO_OFS_STATUS      5'h14

// Control register layout
`define TPIO_CTRL_W          8
`define TPIO_CTRL_RESET      8'h00
`define TPIO_FIELD_W         4
`define TPIO_FIELD_A_LSB     0
`define TPIO_FIELD_C_LSB     4

// Function field bit positions
`define TPIO_FUNC_CAPTURE    3
`define TPIO_FUNC_PROHIBIT   2
`define TPIO_FUNC_INIT       2
`define TPIO_FUNC_BOTH       1

// Compare actions held in field bits 1:0
`define TPIO_ACT_OFF         2'h0
`define TPIO_ACT_LOW         2'h1
`define TPIO_ACT_HIGH        2'h2
`define TPIO_ACT_TOGGLE      2'h3

// General registers
`define TPIO_GEN_W           16
`define TPIO_GEN_RESET       16'hFFFF
`define TPIO_ENTRIES         3

// Status register layout
`define TPIO_STAT_LEVEL_LSB  0
`define TPIO_STAT_DRIVE_LSB  4
`define TPIO_STAT_BUFFER     8

`endif

// [core/timer_pin_io_control.v]
// Purpose: Pin function selection for three timer general registers
// Assumes: Counter, compare-match strobes and buffer mode from the timer
// Notes:   Entry 0 is channel 0 register A, 1 is channel 0 register C,
//          2 is channel 1 register A
`include "timer_pin_io_map.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_pin_io_control (
   // Clock and reset
   input  wire                       sys_clk,
   input  wire                       rst_n,
   // Avalon-MM slave
   input  wire [`TPIO_ADDR_W-1:0]    address,
   input  wire                       read,
   input  wire                       write,
   input  wire [`TPIO_DATA_W-1:0]    writedata,
   input  wire [`TPIO_BE_W-1:0]      byteenable,
   output reg  [`TPIO_DATA_W-1:0]    readdata,
   output wire                       waitrequest,
   // Timer core
   input  wire [`TPIO_GEN_W-1:0]     chan0Count,
   input  wire [`TPIO_GEN_W-1:0]     chan1Count,
   input  wire [`TPIO_ENTRIES-1:0]   compareMatch,
   input  wire                       bufferModeA,
   output wire [`TPIO_GEN_W-1:0]     chan0GeneralRegA,
   output wire [`TPIO_GEN_W-1:0]     chan0GeneralRegC,
   output wire [`TPIO_GEN_W-1:0]     chan1GeneralRegA,
   output wire [`TPIO_ENTRIES-1:0]   captureEvent,
   // Channel 0 pin A
   input  wire                       chan0PinAIn,
   output wire                       chan0PinAOut,
   output wire                       chan0PinAOeN,
   // Channel 0 pin C
   input  wire                       chan0PinCIn,
   output wire                       chan0PinCOut,
   output wire                       chan0PinCOeN,
   // Channel 1 pin A
   input  wire                       chan1PinAIn,
   output wire                       chan1PinAOut,
   output wire                       chan1PinAOeN
);

   // Bus handshake state
   reg                             ack_reg;
   wire                            busReq;
   wire                            busWrite;
   wire                            busRead;

   // Control registers
   reg  [`TPIO_CTRL_W-1:0]         chan0PinCtrlHigh_reg;
   reg  [`TPIO_CTRL_W-1:0]         chan1PinCtrl_reg;
   wire [4*`TPIO_FIELD_W-1:0]      fieldVec;
   wire [4*`TPIO_FIELD_W-1:0]      fieldNewVec;
   wire [`TPIO_ENTRIES-1:0]        fieldWr;

   // Per-entry vectors shared across the generate loop
   wire [`TPIO_ENTRIES-1:0]        pinInVec;
   wire [`TPIO_ENTRIES-1:0]        pinLevelVec;
   wire [`TPIO_ENTRIES-1:0]        pinOeNVec;
   wire [`TPIO_ENTRIES-1:0]        pinSyncVec;
   wire [`TPIO_ENTRIES-1:0]        capHitVec;
   wire [`TPIO_ENTRIES-1:0]        cmpHitVec;
   wire [`TPIO_ENTRIES-1:0]        genWr;
   wire [3*`TPIO_GEN_W-1:0]        genVec;
   wire [`TPIO_GEN_W-1:0]          genWrData;
   wire                            lowLane;
   wire                            lowWord;

   // Read mux
   reg  [`TPIO_DATA_W-1:0]         readValue;

   // One wait cycle, then the answer; keeps read data registered
   assign busReq      = read | write;
   assign waitrequest = busReq & ~ack_reg;
   assign busWrite    = write & ack_reg;
   assign busRead     = read & ~ack_reg;

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else if (ack_reg) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= busReq;
      end
   end

   // Byte lanes for the narrow registers
   assign lowLane   = byteenable[0];
   assign lowWord   = byteenable[0] & byteenable[1];
   assign genWrData = writedata[`TPIO_GEN_W-1:0];

   // Control registers; only the low lane carries them
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         chan0PinCtrlHigh_reg <= `TPIO_CTRL_RESET;
         chan1PinCtrl_reg     <= `TPIO_CTRL_RESET;
      end else if (busWrite && lowLane) begin
         if (address == `TPIO_OFS_CH0_CTRL) begin
            chan0PinCtrlHigh_reg <= writedata[`TPIO_CTRL_W-1:0];
         end
         if (address == `TPIO_OFS_CH1_CTRL) begin
            chan1PinCtrl_reg <= {4'h0, writedata[`TPIO_FIELD_W-1:0]};
         end
      end
   end

   // Fields and their freshly written values, one nibble per entry
   assign fieldVec = {4'h0,
      chan1PinCtrl_reg[`TPIO_FIELD_A_LSB +: `TPIO_FIELD_W],
      chan0PinCtrlHigh_reg[`TPIO_FIELD_C_LSB +: `TPIO_FIELD_W],
      chan0PinCtrlHigh_reg[`TPIO_FIELD_A_LSB +: `TPIO_FIELD_W]};
   assign fieldNewVec = {4'h0,
      writedata[`TPIO_FIELD_A_LSB +: `TPIO_FIELD_W],
      writedata[`TPIO_FIELD_C_LSB +: `TPIO_FIELD_W],
      writedata[`TPIO_FIELD_A_LSB +: `TPIO_FIELD_W]};
   assign fieldWr[0] = busWrite & lowLane &
                       (address == `TPIO_OFS_CH0_CTRL);
   assign fieldWr[1] = fieldWr[0];
   assign fieldWr[2] = busWrite & lowLane &
                       (address == `TPIO_OFS_CH1_CTRL);

   // General register writes need both low lanes
   assign genWr[0] = busWrite & lowWord & (address == `TPIO_OFS_CH0_GEN_A);
   assign genWr[1] = busWrite & lowWord & (address == `TPIO_OFS_CH0_GEN_C);
   assign genWr[2] = busWrite & lowWord & (address == `TPIO_OFS_CH1_GEN_A);

   // Each register looks at its own pin
   assign pinInVec = {chan1PinAIn, chan0PinCIn, chan0PinAIn};

   genvar i;
   generate
      for (i = 0; i < `TPIO_ENTRIES; i = i + 1) begin : entry
         wire [`TPIO_FIELD_W-1:0] field;
         wire [`TPIO_FIELD_W-1:0] fieldNew;
         wire                     inhibit;
         wire                     cmpMode;
         wire                     capMode;
         wire                     rise;
         wire                     fall;
         wire                     edgeHit;
         wire [`TPIO_GEN_W-1:0]   count;
         wire                     bufLoad;
         wire                     bufShift;
         reg                      sync1_reg;
         reg                      sync2_reg;
         reg                      sync3_reg;
         reg                      level_reg;
         reg                      oeN_reg;
         reg  [`TPIO_GEN_W-1:0]   gen_reg;

         assign field    = fieldVec[i*`TPIO_FIELD_W +: `TPIO_FIELD_W];
         assign fieldNew = fieldNewVec[i*`TPIO_FIELD_W +: `TPIO_FIELD_W];

         // Register C is a buffer in buffer mode; its field only sets the undriven output level
         assign inhibit = (i == 1) ? bufferModeA : 1'b0;

         assign cmpMode = ~field[`TPIO_FUNC_CAPTURE];
         // 11xx falls in neither mode, so it does nothing at all
         assign capMode = field[`TPIO_FUNC_CAPTURE] &
                          ~field[`TPIO_FUNC_PROHIBIT];

         // Pin synchroniser; only the second and third stages are compared
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               sync1_reg <= 1'b0;
               sync2_reg <= 1'b0;
               sync3_reg <= 1'b0;
            end else begin
               sync1_reg <= pinInVec[i];
               sync2_reg <= sync1_reg;
               sync3_reg <= sync2_reg;
            end
         end

         assign rise = sync2_reg & ~sync3_reg;
         assign fall = ~sync2_reg & sync3_reg;

         assign edgeHit = field[`TPIO_FUNC_BOTH] ? (rise | fall) :
                          field[0] ? fall :
                          rise;

         // No event of any kind from register C in buffer mode
         assign capHitVec[i] = capMode & edgeHit & ~inhibit;
         assign cmpHitVec[i] = cmpMode & compareMatch[i] & ~inhibit;

         assign count = (i == 2) ? chan1Count : chan0Count;

         // Buffer transfers between A and C of channel 0
         if (i == 0) begin : bufA
            assign bufLoad  = bufferModeA & cmpMode & compareMatch[0];
            assign bufShift = 1'b0;
         end else if (i == 1) begin : bufC
            assign bufLoad  = 1'b0;
            assign bufShift = bufferModeA & capHitVec[0];
         end else begin : bufNone
            assign bufLoad  = 1'b0;
            assign bufShift = 1'b0;
         end

         // Capture outranks a bus write landing in the same cycle
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               gen_reg <= `TPIO_GEN_RESET;
            end else if (capHitVec[i]) begin
               gen_reg <= count;
            end else if (bufShift) begin
               gen_reg <= genVec[0 +: `TPIO_GEN_W];
            end else if (bufLoad) begin
               gen_reg <= genVec[`TPIO_GEN_W +: `TPIO_GEN_W];
            end else if (genWr[i]) begin
               gen_reg <= genWrData;
            end
         end

         // Pin level: initial level on field write, then match actions
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               level_reg <= 1'b0;
            end else if (fieldWr[i] && !fieldNew[`TPIO_FUNC_CAPTURE] &&
                         fieldNew[1:0] != `TPIO_ACT_OFF) begin
               level_reg <= fieldNew[`TPIO_FUNC_INIT];
            end else if (cmpHitVec[i]) begin
               case (field[1:0])
                  `TPIO_ACT_LOW:    level_reg <= 1'b0;
                  `TPIO_ACT_HIGH:   level_reg <= 1'b1;
                  `TPIO_ACT_TOGGLE: level_reg <= ~level_reg;
                  default:          level_reg <= level_reg;
               endcase
            end
         end

         // Drive only in compare mode with an action chosen
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               oeN_reg <= 1'b1;
            end else begin
               oeN_reg <= ~(cmpMode & (field[1:0] != `TPIO_ACT_OFF) &
                            ~inhibit);
            end
         end

         assign pinLevelVec[i] = level_reg;
         assign pinOeNVec[i]   = oeN_reg;
         assign pinSyncVec[i]  = sync2_reg;
         assign genVec[i*`TPIO_GEN_W +: `TPIO_GEN_W] = gen_reg;
      end
   endgenerate

   // Timer side
   assign chan0GeneralRegA = genVec[0 +: `TPIO_GEN_W];
   assign chan0GeneralRegC = genVec[`TPIO_GEN_W +: `TPIO_GEN_W];
   assign chan1GeneralRegA = genVec[2*`TPIO_GEN_W +: `TPIO_GEN_W];
   assign captureEvent     = capHitVec;

   // Pins
   assign chan0PinAOut = pinLevelVec[0];
   assign chan0PinAOeN = pinOeNVec[0];
   assign chan0PinCOut = pinLevelVec[1];
   assign chan0PinCOeN = pinOeNVec[1];
   assign chan1PinAOut = pinLevelVec[2];
   assign chan1PinAOeN = pinOeNVec[2];

   // Read mux; unmapped offsets read as zero
   always @* begin
      readValue = {`TPIO_DATA_W{1'b0}};
      case (address)
         `TPIO_OFS_CH0_CTRL:
            readValue[`TPIO_CTRL_W-1:0] = chan0PinCtrlHigh_reg;
         `TPIO_OFS_CH1_CTRL:
            readValue[`TPIO_CTRL_W-1:0] = chan1PinCtrl_reg;
         `TPIO_OFS_CH0_GEN_A:
            readValue[`TPIO_GEN_W-1:0] = genVec[0 +: `TPIO_GEN_W];
         `TPIO_OFS_CH0_GEN_C:
            readValue[`TPIO_GEN_W-1:0] = genVec[`TPIO_GEN_W +: `TPIO_GEN_W];
         `TPIO_OFS_CH1_GEN_A:
            readValue[`TPIO_GEN_W-1:0] =
               genVec[2*`TPIO_GEN_W +: `TPIO_GEN_W];
         `TPIO_OFS_STATUS: begin
            readValue[`TPIO_STAT_LEVEL_LSB +: `TPIO_ENTRIES] = pinSyncVec;
            readValue[`TPIO_STAT_DRIVE_LSB +: `TPIO_ENTRIES] = ~pinOeNVec;
            readValue[`TPIO_STAT_BUFFER] = bufferModeA;
         end
         default:
            readValue = {`TPIO_DATA_W{1'b0}};
      endcase
   end

   // Read data captured in the wait cycle, held until the next read
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         readdata <= {`TPIO_DATA_W{1'b0}};
      end else if (busRead) begin
         readdata <= readValue;
      end
   end

endmodule

`default_nettype wire

// [verif/timer_pin_io_props.sv]
// Purpose: Concurrent checks on the pin function block ports
// Assumes: Control fields tracked from bus writes that land
// Notes:   Bound to the block after the checker
`timescale 1ns/1ps
`default_nettype none
module timer_pin_io_props (
   // Clock, reset and bus
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic        waitrequest,
   // Timer side
   input wire logic [15:0] chan0Count,
   input wire logic [15:0] chan1Count,
   input wire logic [2:0]  compareMatch,
   input wire logic        bufferModeA,
   input wire logic [15:0] chan0GeneralRegA,
   input wire logic [15:0] chan1GeneralRegA,
   input wire logic [2:0]  captureEvent,
   // Pins
   input wire logic        chan0PinAOut,
   input wire logic        chan0PinAOeN,
   input wire logic        chan1PinAOut
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] ctrl0Reg;
   logic [3:0] ctrl1Reg;
   wire        landHit = write && !waitrequest && byteenable[0];
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl0Reg <= 8'h00;
         ctrl1Reg <= 4'h0;
      end else if (landHit && address == 5'h00) begin
         ctrl0Reg <= writedata[7:0];
      end else if (landHit && address == 5'h04) begin
         ctrl1Reg <= writedata[3:0];
      end
   end
   // Field lands carrying a compare action
   sequence s_arm0;
      landHit && address == 5'h00 && !writedata[3] && writedata[1:0] != 2'h0;
   endsequence
   sequence s_match0;
      compareMatch[0] && !ctrl0Reg[3];
   endsequence
   a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one cycle");
   a_idle_nowait: assert property (!read && !write |-> !waitrequest)
      else $error("waitrequest high while idle");
   a_capture_a0: assert property (captureEvent[0] |=>
      chan0GeneralRegA == $past(chan0Count)) else $error("A0 capture value");
   a_capture_a1: assert property (captureEvent[2] |=>
      chan1GeneralRegA == $past(chan1Count)) else $error("A1 capture value");
   a_buffer_quiet: assert property (bufferModeA && $past(bufferModeA) |->
      !captureEvent[1]) else $error("C0 event in buffer mode");
   a_match_low: assert property (s_match0 ##0 ctrl0Reg[1:0] == 2'h1 |=>
      !chan0PinAOut) else $error("pin not low after match");
   a_match_high: assert property (compareMatch[2] && !ctrl1Reg[3] &&
      ctrl1Reg[1:0] == 2'h2 |=> chan1PinAOut) else $error("pin not high");
   a_match_toggle: assert property (s_match0 ##0 ctrl0Reg[1:0] == 2'h3 |=>
      chan0PinAOut != $past(chan0PinAOut)) else $error("pin not toggled");
   a_init_level: assert property (s_arm0 |=>
      chan0PinAOut == $past(writedata[2])) else $error("initial level wrong");
   a_drive_on: assert property (ctrl0Reg == $past(ctrl0Reg) &&
      !ctrl0Reg[3] && ctrl0Reg[1:0] != 2'h0 |-> !chan0PinAOeN)
      else $error("pin A0 not driven");
endmodule
bind timer_pin_io_control timer_pin_io_props i_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
   .chan0Count(chan0Count), .chan1Count(chan1Count),
   .compareMatch(compareMatch), .bufferModeA(bufferModeA),
   .chan0GeneralRegA(chan0GeneralRegA), .chan1GeneralRegA(chan1GeneralRegA),
   .captureEvent(captureEvent), .chan0PinAOut(chan0PinAOut),
   .chan0PinAOeN(chan0PinAOeN), .chan1PinAOut(chan1PinAOut));
`default_nettype wire

// [verif/pin_partner.sv]
// Purpose: Outside world on the three timer pins
// Assumes: Block output wins while its enable is low
// Notes:   No pull; an undriven pin follows the outside source
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // Pins
   input  wire logic [2:0] pinOut,
   input  wire logic [2:0] pinOeN,
   input  wire logic [2:0] extLevel,
   output logic      [2:0] pinLevel
);
   assign pinLevel = (~pinOeN & pinOut) | (pinOeN & extLevel);
endmodule
`default_nettype wire

// [verif/test_timer_pin_io_control.sv]
// Purpose: Self-checking bench for the pin function block
// Assumes: One idle cycle between bus transfers
// Notes:   Pin levels and captures predicted by a small model
`timescale 1ns/1ps
`default_nettype none
module test_timer_pin_io_control;
   logic        sys_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [4:0]  address = 5'h00;
   logic        read = 1'h0;
   logic        write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'hF;
   logic [15:0] chan0Count = 16'h0;
   logic [15:0] chan1Count = 16'h0;
   logic [2:0]  compareMatch = 3'h0;
   logic        bufferModeA = 1'h0;
   logic [2:0]  extLevel = 3'h0;
   logic [31:0] rd, expCount;
   logic        lvl, got;
   wire  [31:0] readdata;
   wire         waitrequest;
   wire  [15:0] genA0, genC0, genA1;
   wire  [2:0]  captureEvent, pinOut, pinOeN, pinLevel;
   int          err_total = 0;
   int          compares = 0;
   int          e, f, k, r, n;
   int          fld[3] = '{0, 0, 0};
   timer_pin_io_control i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .chan0Count(chan0Count), .chan1Count(chan1Count),
      .compareMatch(compareMatch), .bufferModeA(bufferModeA),
      .chan0GeneralRegA(genA0), .chan0GeneralRegC(genC0),
      .chan1GeneralRegA(genA1), .captureEvent(captureEvent),
      .chan0PinAIn(pinLevel[0]), .chan0PinAOut(pinOut[0]),
      .chan0PinAOeN(pinOeN[0]), .chan0PinCIn(pinLevel[1]),
      .chan0PinCOut(pinOut[1]), .chan0PinCOeN(pinOeN[1]),
      .chan1PinAIn(pinLevel[2]), .chan1PinAOut(pinOut[2]),
      .chan1PinAOeN(pinOeN[2]));
   pin_partner i_pins (.pinOut(pinOut), .pinOeN(pinOeN),
      .extLevel(extLevel), .pinLevel(pinLevel));
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      chan0Count <= 16'($urandom);
      chan1Count <= 16'($urandom);
   end
   task automatic complete_run;
      $display("Compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int t;
      t = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge sys_clk);
         t++;
      end while (waitrequest !== 1'h0 && t < 20);
      if (waitrequest !== 1'h0) begin
         err_total++;
         complete_run();
      end
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge sys_clk);
   endtask
   // Upper data bits random; the block must ignore them
   task automatic setf(input int i, input int v);
      fld[i] = v;
      if (i == 2) begin
         bus(1'h1, 5'h04, {28'($urandom), 4'(fld[2])});
      end else begin
         bus(1'h1, 5'h00, {24'($urandom), 4'(fld[1]), 4'(fld[0])});
      end
   endtask
   initial begin
      void'($urandom(32'h9CF5));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(posedge sys_clk);
      for (k = 0; k < 7; k++) begin
         bus(1'h0, 5'(4 * k), 32'h0);
         check(rd, (k >= 2 && k <= 4) ? 32'hFFFF : 32'h0);
      end
      bus(1'h1, 5'h18, $urandom);
      bus(1'h0, 5'h18, 32'h0);
      check(rd, 32'h0);
      expCount = {16'h0, 16'($urandom)};
      bus(1'h1, 5'h10, expCount);
      bus(1'h0, 5'h10, 32'h0);
      check(rd, expCount);
      for (e = 0; e < 3; e++) begin
         for (f = 0; f < 8; f++) begin
            setf(e, f);
            @(posedge sys_clk);
            lvl = f[2];
            check(pinOeN[e], f[1:0] == 0);
            if (f[1:0] != 0) check(pinOut[e], lvl);
            compareMatch[e] <= 1'h1;
            @(posedge sys_clk);
            compareMatch[e] <= 1'h0;
            @(posedge sys_clk);
            lvl = f[1:0] == 1 ? 1'h0 : f[1:0] == 2 ? 1'h1 : !lvl;
            if (f[1:0] != 0) check(pinOut[e], lvl);
         end
      end
      bus(1'h0, 5'h00, 32'h0);
      check(rd, {24'h0, 4'(fld[1]), 4'(fld[0])});
      // Last capture case of C0 runs in buffer mode
      for (e = 0; e < 3; e++) begin
         for (k = 0; k < 6; k++) begin
            // Prohibited 11xx never written; case 4 is output disabled
            f = k < 4 ? 8 + k : k == 4 ? 0 : 10;
            bufferModeA <= k == 5 && e == 1;
            setf(e, f);
            repeat (6) @(posedge sys_clk);
            for (r = 0; r < 2; r++) begin
               extLevel[e] <= r == 0;
               got = 1'h0;
               for (n = 0; n < 8; n++) begin
                  @(posedge sys_clk);
                  #1;
                  if (captureEvent[e] === 1'h1 && !got) begin
                     got = 1'h1;
                     expCount = e == 2 ? chan1Count : chan0Count;
                  end
               end
               @(posedge sys_clk);
               check(got, k != 4 && !(k == 5 && e == 1) &&
                     (f[1] || f[0] == r));
               if (got) begin
                  bus(1'h0, 5'(8 + 4 * e), 32'h0);
                  check(rd, {16'h0, expCount[15:0]});
               end
            end
         end
      end
      complete_run();
   end
endmodule
`default_nettype wire
